// ===== verilog/sdri_top.sv
// Serial link front end: shifts words in, decodes them and drives all channels.
`timescale 1ns/1ps
// What this block does
// - Three-wire link: frame low, shift clock, data; sole path for register writes.
// - While frame is low, data is shifted in on every falling shift clock.
// - High select from bit 13, low select from bit 14.
// - 00 global control, 01 channel control, high select 1 data write.
// - Global control writes ignore the channel address.
// - Each channel has its own control register; only the addressed one changes.
// - Channel control: address 12..10, bias 9..8, sleep bit 4, clear bit 3.
// - Data writes: bit 15 zero picks coarse buffer, one picks fine buffer.
// - Coarse buffer holds ten bits, fine buffer eight; two low bits ignored.
// - Coarse write: address bits 12..10, code bits 9..0.
// - Fine write: address bits 12..10, code bits 9..2.
// - Top address bit decoded only in the eight-channel build.
// - Falling update input copies every buffer into its output register together; coarse output takes the clear code where the channel clear bit is one.
// - Hardware clear resets coarse and fine buffers and outputs.
// - Global soft clear holds all coarse registers at clear level; fine untouched.
// - Power-down zero turns reference and channels off; contents kept.
// - Coding select: zero two's complement, one offset binary, for all channels.
// - Minimum code is 000 in offset binary, 200 in two's complement.
// - Global sleep one idles all channels, reference stays on.
// - Bias pair: 00 half supply, 01 internal, 10 external, 11 undefined.
// - Channel sleep zero idles that channel, one wakes it.
// - Channel clear affects coarse output only, after an update pulse.
// - Reset: power-down and global sleep one, channel sleep and clear one, bias zero.
module sdri_top #(
	parameter int NUM_CH = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_frame_sync_n,
	input wire logic i_serial_shift_clock,
	input wire logic i_serial_data_in,
	input wire logic i_output_update_n,
	input wire logic i_clear_n,
	output logic [NUM_CH*sdri_pkg::MAIN_W-1:0] o_main_code,
	output logic [NUM_CH*sdri_pkg::SUB_W-1:0] o_sub_code,
	output logic [NUM_CH*sdri_pkg::BIAS_W-1:0] o_bias_select,
	output logic [NUM_CH-1:0] o_chan_active,
	output logic o_ref_on,
	output logic o_coding_select,
	output logic [sdri_pkg::MAIN_W-1:0] o_min_code
);
	import sdri_pkg::*;

	typedef struct packed {
		sdri_state_t st;
		logic sclk_q;
		logic upd_q;
		logic [WORD_W-1:0] shreg;
		logic [CNT_W-1:0] cnt;
		logic [WORD_W-1:0] word;
		logic wr_sys;
		logic wr_ctrl;
		logic wr_main;
		logic wr_sub;
		logic update;
		logic hw_clear;
		logic coding;
		logic pd_n;
		logic gsleep;
		logic gclr;
		logic sys_on;
		logic ref_on;
		logic [MAIN_W-1:0] min_code;
		logic [MAIN_W-1:0] clear_code;
	} sdri_top_state_t;

	sdri_top_state_t s;
	sdri_top_state_t next_s;
	logic [PIN_N-1:0] pins;
	logic frame_low;
	logic sclk_fall;
	logic upd_fall;
	logic sel_hi;
	logic sel_lo;

	// ****************************************
	// Pin synchronisation and edge finding
	// ****************************************
	sdri_sync #(
		.WIDTH(PIN_N),
		.RESET_VAL(PIN_IDLE)
	) u_pins (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_async({i_clear_n, i_output_update_n, i_serial_data_in, i_serial_shift_clock, i_frame_sync_n}),
		.o_sync(pins)
	);

	assign frame_low = ~pins[PIN_FRAME];
	assign sclk_fall = s.sclk_q & ~pins[PIN_SCLK];
	assign upd_fall = s.upd_q & ~pins[PIN_UPD];
	assign sel_hi = s.shreg[DEST_HI_BIT];
	assign sel_lo = s.shreg[DEST_LO_BIT];

	// ****************************************
	// Shift, decode and global control
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.wr_sys = 1'h0;
		next_s.wr_ctrl = 1'h0;
		next_s.wr_main = 1'h0;
		next_s.wr_sub = 1'h0;
		next_s.sclk_q = pins[PIN_SCLK];
		next_s.upd_q = pins[PIN_UPD];
		case (s.st)
			ST_IDLE: begin
				if (frame_low) begin
					next_s.st = ST_SHIFT;
					next_s.cnt = '0;
				end
			end
			ST_SHIFT: begin
				if (!frame_low) begin
					// Short or long frames are dropped without touching any register.
					if (s.cnt == CNT_FULL) begin
						next_s.word = s.shreg;
						next_s.wr_sys = !sel_hi && !sel_lo;
						next_s.wr_ctrl = !sel_hi && sel_lo;
						next_s.wr_main = sel_hi && !s.shreg[TARGET_BIT];
						next_s.wr_sub = sel_hi && s.shreg[TARGET_BIT];
						next_s.st = ST_COMMIT;
					end else begin
						next_s.st = ST_IDLE;
					end
				end else if (sclk_fall) begin
					next_s.shreg = {s.shreg[WORD_W-2:0], pins[PIN_SDI]};
					if (s.cnt != CNT_OVER) begin
						next_s.cnt = CNT_W'(s.cnt + 5'h01);
					end
				end
			end
			ST_COMMIT: begin
				if (s.wr_sys) begin
					next_s.coding = s.word[CODING_BIT];
					next_s.pd_n = s.word[PD_N_BIT];
					next_s.gsleep = s.word[GSLEEP_BIT];
					next_s.gclr = s.word[GCLR_BIT];
				end
				next_s.st = ST_IDLE;
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase
		next_s.update = upd_fall;
		next_s.hw_clear = ~pins[PIN_CLR];
		next_s.sys_on = s.pd_n & ~s.gsleep;
		next_s.ref_on = s.pd_n;
		next_s.min_code = s.coding ? MIN_CODE_OFFSET : MIN_CODE_TWOS;
		next_s.clear_code = s.coding ? CLEAR_CODE_OFFSET : CLEAR_CODE_TWOS;
		if (i_srst) begin
			next_s.st = ST_IDLE;
			next_s.sclk_q = PIN_IDLE[PIN_SCLK];
			next_s.upd_q = PIN_IDLE[PIN_UPD];
			next_s.shreg = '0;
			next_s.cnt = '0;
			next_s.word = '0;
			next_s.update = 1'h0;
			next_s.hw_clear = 1'h0;
			next_s.coding = RST_CODING;
			next_s.pd_n = RST_PD_N;
			next_s.gsleep = RST_GSLEEP;
			next_s.gclr = RST_GCLR;
			next_s.sys_on = 1'h0;
			next_s.ref_on = RST_PD_N;
			next_s.min_code = MIN_CODE_TWOS;
			next_s.clear_code = CLEAR_CODE_TWOS;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		s <= next_s;
	end

	assign o_ref_on = s.ref_on;
	assign o_coding_select = s.coding;
	assign o_min_code = s.min_code;

	// ****************************************
	// Channels
	// ****************************************
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		sdri_channel #(
			.NUM_CH(NUM_CH),
			.CH_INDEX(ch)
		) u_ch (
			.i_ref_clk(i_ref_clk),
			.i_srst(i_srst),
			.i_word(s.word),
			.i_wr_ctrl(s.wr_ctrl),
			.i_wr_main(s.wr_main),
			.i_wr_sub(s.wr_sub),
			.i_update(s.update),
			.i_sys_clear(s.gclr),
			.i_hw_clear(s.hw_clear),
			.i_sys_on(s.sys_on),
			.i_clear_code(s.clear_code),
			.o_main_code(o_main_code[ch*MAIN_W +: MAIN_W]),
			.o_sub_code(o_sub_code[ch*SUB_W +: SUB_W]),
			.o_bias_select(o_bias_select[ch*BIAS_W +: BIAS_W]),
			.o_active(o_chan_active[ch])
		);
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);

	property p_shift_in;
		(s.st == ST_SHIFT && frame_low && sclk_fall) |=> s.shreg[0] == $past(pins[PIN_SDI]);
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("Serial bit not shifted in.");

	property p_commit_sixteen;
		(s.wr_sys || s.wr_ctrl || s.wr_main || s.wr_sub) |-> $past(s.cnt) == CNT_FULL && $past(s.st) == ST_SHIFT;
	endproperty
	a_commit_sixteen: assert property (p_commit_sixteen) else $error("Commit without sixteen bits.");

	property p_sys_decode;
		s.wr_sys |-> !s.word[DEST_HI_BIT] && !s.word[DEST_LO_BIT];
	endproperty
	a_sys_decode: assert property (p_sys_decode) else $error("Global write with wrong selects.");

	property p_sys_apply;
		s.wr_sys |=> s.pd_n == $past(s.word[PD_N_BIT]) && s.gsleep == $past(s.word[GSLEEP_BIT])
			&& s.coding == $past(s.word[CODING_BIT]);
	endproperty
	a_sys_apply: assert property (p_sys_apply) else $error("Global word not applied.");

	property p_update_pulse;
		upd_fall |=> s.update ##1 !s.update;
	endproperty
	a_update_pulse: assert property (p_update_pulse) else $error("Update pulse missing.");

	property p_sleep_off;
		(s.gsleep || !s.pd_n) |=> ##1 o_chan_active == '0;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("Channel active while asleep.");

	property p_reset_vals;
		$fell(i_srst) |-> s.pd_n && s.gsleep && o_chan_active == '0;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("Wrong reset state.");

	property p_ctrl_decode;
		s.wr_ctrl |-> !s.word[DEST_HI_BIT] && s.word[DEST_LO_BIT];
	endproperty
	a_ctrl_decode: assert property (p_ctrl_decode) else $error("Channel write with wrong selects.");

	property p_data_decode;
		(s.wr_main || s.wr_sub) |-> s.word[DEST_HI_BIT] && (s.wr_sub == s.word[TARGET_BIT]);
	endproperty
	a_data_decode: assert property (p_data_decode) else $error("Data write aimed at wrong buffer.");

	property p_one_strobe;
		$onehot0({s.wr_sys, s.wr_ctrl, s.wr_main, s.wr_sub});
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("More than one write strobe.");

	property p_short_drop;
		(s.st == ST_SHIFT && !frame_low && s.cnt != CNT_FULL) |=> s.st == ST_IDLE
			&& !(s.wr_sys || s.wr_ctrl || s.wr_main || s.wr_sub);
	endproperty
	a_short_drop: assert property (p_short_drop) else $error("Wrong-length frame committed.");

	property p_commit_once;
		s.st == ST_COMMIT |=> s.st == ST_IDLE && !(s.wr_sys || s.wr_ctrl || s.wr_main || s.wr_sub);
	endproperty
	a_commit_once: assert property (p_commit_once) else $error("Commit did not return to idle.");

	property p_cnt_bound;
		s.cnt <= CNT_OVER;
	endproperty
	a_cnt_bound: assert property (p_cnt_bound) else $error("Bit counter ran past its limit.");

	property p_min_offset;
		s.coding |=> s.min_code == MIN_CODE_OFFSET;
	endproperty
	a_min_offset: assert property (p_min_offset) else $error("Minimum code wrong for offset binary.");

	property p_min_twos;
		!s.coding |=> s.min_code == MIN_CODE_TWOS;
	endproperty
	a_min_twos: assert property (p_min_twos) else $error("Minimum code wrong for twos complement.");

	property p_ref_off;
		!s.pd_n |=> !o_ref_on;
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("Reference on during power-down.");

	property p_ref_stays;
		s.pd_n |=> o_ref_on;
	endproperty
	a_ref_stays: assert property (p_ref_stays) else $error("Reference off while powered.");

	property p_hw_clear_seen;
		!pins[PIN_CLR] |=> s.hw_clear;
	endproperty
	a_hw_clear_seen: assert property (p_hw_clear_seen) else $error("Hardware clear not taken.");

	property p_global_hold;
		(s.st != ST_COMMIT) |=> $stable(s.pd_n) && $stable(s.gsleep)
			&& $stable(s.coding) && $stable(s.gclr);
	endproperty
	a_global_hold: assert property (p_global_hold) else $error("Global control changed unwritten.");

	c_sys_write: cover property (s.wr_sys);
	c_ctrl_write: cover property (s.wr_ctrl);
	c_data_then_update: cover property (s.wr_main ##[1:200] s.update);
endmodule

// ===== verilog/sdri_pkg.sv
// Shared constants and types for the serial DAC register interface.
package sdri_pkg;

	// ****************************************
	// Input word layout
	// ****************************************
	localparam int WORD_W = 16;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
	localparam logic [CNT_W-1:0] CNT_OVER = 5'h11;
	localparam int TARGET_BIT = 15;
	localparam int DEST_LO_BIT = 14;
	localparam int DEST_HI_BIT = 13;
	localparam int ADDR_HI = 12;
	localparam int ADDR_LO = 10;
	localparam int ADDR_W = 3;
	localparam int BIAS_HI = 9;
	localparam int BIAS_LO = 8;
	localparam int BIAS_W = 2;
	localparam int SLEEP_N_BIT = 4;
	localparam int CLR_REQ_BIT = 3;
	localparam int CODING_BIT = 6;
	localparam int PD_N_BIT = 5;
	localparam int GSLEEP_BIT = 4;
	localparam int GCLR_BIT = 3;
	localparam int MAIN_HI = 9;
	localparam int MAIN_LO = 0;
	localparam int MAIN_W = 10;
	localparam int SUB_HI = 9;
	localparam int SUB_LO = 2;
	localparam int SUB_W = 8;

	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic RST_PD_N = 1'h1;
	localparam logic RST_GSLEEP = 1'h1;
	localparam logic RST_CODING = 1'h0;
	localparam logic RST_GCLR = 1'h0;
	localparam logic RST_SLEEP_N = 1'h1;
	localparam logic RST_CLR_REQ = 1'h1;
	localparam logic [BIAS_W-1:0] RST_BIAS = 2'h0;
	localparam logic [MAIN_W-1:0] MIN_CODE_OFFSET = 10'h000;
	localparam logic [MAIN_W-1:0] MIN_CODE_TWOS = 10'h200;
	localparam logic [MAIN_W-1:0] CLEAR_CODE_OFFSET = 10'h000;
	localparam logic [MAIN_W-1:0] CLEAR_CODE_TWOS = 10'h000;
	localparam logic [SUB_W-1:0] SUB_CLEAR = 8'h00;

	// ****************************************
	// Pin synchroniser lanes
	// ****************************************
	localparam int PIN_N = 5;
	localparam int PIN_FRAME = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_SDI = 2;
	localparam int PIN_UPD = 3;
	localparam int PIN_CLR = 4;
	// Idle levels: frame, update and clear high; shift clock and data low.
	localparam logic [PIN_N-1:0] PIN_IDLE = 5'h19;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SHIFT = 2'h1,
		ST_COMMIT = 2'h3
	} sdri_state_t;

endpackage

// ===== verilog/sdri_sync.sv
// Two-stage synchroniser for pins entering the reference clock domain.
`timescale 1ns/1ps
module sdri_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sdri_sync_state_t;

	sdri_sync_state_t s;
	sdri_sync_state_t next_s;

	always_comb begin
		next_s.meta = i_async;
		next_s.stable = s.meta;
		if (i_srst) begin
			next_s.meta = RESET_VAL;
			next_s.stable = RESET_VAL;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		s <= next_s;
	end

	assign o_sync = s.stable;
endmodule

// ===== verilog/sdri_channel.sv
// Per-channel control register, double-buffered data and output registers.
`timescale 1ns/1ps
module sdri_channel #(
	parameter int NUM_CH = 8,
	parameter int CH_INDEX = 0
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic [sdri_pkg::WORD_W-1:0] i_word,
	input wire logic i_wr_ctrl,
	input wire logic i_wr_main,
	input wire logic i_wr_sub,
	input wire logic i_update,
	input wire logic i_sys_clear,
	input wire logic i_hw_clear,
	input wire logic i_sys_on,
	input wire logic [sdri_pkg::MAIN_W-1:0] i_clear_code,
	output logic [sdri_pkg::MAIN_W-1:0] o_main_code,
	output logic [sdri_pkg::SUB_W-1:0] o_sub_code,
	output logic [sdri_pkg::BIAS_W-1:0] o_bias_select,
	output logic o_active
);
	import sdri_pkg::*;

	localparam logic [ADDR_W-1:0] MY_ADDR = ADDR_W'(CH_INDEX);

	typedef struct packed {
		logic [BIAS_W-1:0] bias;
		logic sleep_n;
		logic clr_req;
		logic [MAIN_W-1:0] buf_main;
		logic [SUB_W-1:0] buf_sub;
		logic [MAIN_W-1:0] out_main;
		logic [SUB_W-1:0] out_sub;
		logic active;
	} sdri_chan_state_t;

	sdri_chan_state_t s;
	sdri_chan_state_t next_s;
	logic [ADDR_W-1:0] addr;
	logic hit;

	assign addr = i_word[ADDR_HI:ADDR_LO];
	// The top address bit only counts when eight channels are built.
	assign hit = (addr[1:0] == MY_ADDR[1:0]) && (NUM_CH <= 4 || addr[2] == MY_ADDR[2]);

	always_comb begin
		next_s = s;
		if (i_wr_ctrl && hit) begin
			next_s.bias = i_word[BIAS_HI:BIAS_LO];
			next_s.sleep_n = i_word[SLEEP_N_BIT];
			next_s.clr_req = i_word[CLR_REQ_BIT];
		end
		if (i_wr_main && hit) begin
			next_s.buf_main = i_word[MAIN_HI:MAIN_LO];
		end
		if (i_wr_sub && hit) begin
			next_s.buf_sub = i_word[SUB_HI:SUB_LO];
		end
		if (i_update) begin
			next_s.out_main = s.clr_req ? i_clear_code : s.buf_main;
			next_s.out_sub = s.buf_sub;
		end
		if (i_sys_clear) begin
			next_s.buf_main = i_clear_code;
			next_s.out_main = i_clear_code;
		end
		if (i_hw_clear) begin
			next_s.buf_main = i_clear_code;
			next_s.out_main = i_clear_code;
			next_s.buf_sub = SUB_CLEAR;
			next_s.out_sub = SUB_CLEAR;
		end
		next_s.active = i_sys_on & s.sleep_n;
		if (i_srst) begin
			next_s.bias = RST_BIAS;
			next_s.sleep_n = RST_SLEEP_N;
			next_s.clr_req = RST_CLR_REQ;
			next_s.buf_main = CLEAR_CODE_TWOS;
			next_s.buf_sub = SUB_CLEAR;
			next_s.out_main = CLEAR_CODE_TWOS;
			next_s.out_sub = SUB_CLEAR;
			next_s.active = 1'h0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		s <= next_s;
	end

	assign o_main_code = s.out_main;
	assign o_sub_code = s.out_sub;
	assign o_bias_select = s.bias;
	assign o_active = s.active;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);

	property p_ctrl_other_chan;
		(i_wr_ctrl && !hit) |=> $stable(s.bias) && $stable(s.sleep_n) && $stable(s.clr_req);
	endproperty
	a_ctrl_other_chan: assert property (p_ctrl_other_chan) else $error("Control write hit wrong channel.");

	property p_sub_field;
		(i_wr_sub && hit && !i_hw_clear) |=> s.buf_sub == $past(i_word[SUB_HI:SUB_LO]);
	endproperty
	a_sub_field: assert property (p_sub_field) else $error("Fine buffer took wrong bits.");

	property p_update_copy;
		(i_update && !i_hw_clear && !i_sys_clear && !s.clr_req) |=> s.out_main == $past(s.buf_main);
	endproperty
	a_update_copy: assert property (p_update_copy) else $error("Update did not copy coarse buffer.");

	property p_hw_clear;
		i_hw_clear |=> s.out_sub == SUB_CLEAR && s.buf_sub == SUB_CLEAR && s.out_main == $past(i_clear_code);
	endproperty
	a_hw_clear: assert property (p_hw_clear) else $error("Hardware clear incomplete.");

	property p_sys_clear_keeps_sub;
		(i_sys_clear && !i_hw_clear && !(i_wr_sub && hit)) |=> $stable(s.buf_sub) && s.buf_main == $past(i_clear_code);
	endproperty
	a_sys_clear_keeps_sub: assert property (p_sys_clear_keeps_sub) else $error("System clear misbehaved.");

	c_update_clear: cover property (i_update && s.clr_req);
endmodule

// ===== tb/sdri_host_model.sv
// Host model that drives the three-wire serial link of the DAC front end.
`timescale 1ns/1ps
module sdri_host_model (
	input wire logic i_ref_clk,
	output logic o_frame_sync_n,
	output logic o_serial_shift_clock,
	output logic o_serial_data_in
);
	initial begin
		o_frame_sync_n = 1'h1;
		o_serial_shift_clock = 1'h0;
		o_serial_data_in = 1'h0;
	end

	// ****
	// Frame sender
	// ****
	// The link clock stands still low between frames; half sets the speed in reference clocks per level.
	task automatic send(input logic [15:0] word, input int nbits, input int half);
		@(negedge i_ref_clk);
		o_frame_sync_n = 1'h0;
		for (int i = 0; i < nbits; i++) begin
			o_serial_data_in = (i < 16) ? word[15-i] : 1'h0;
			o_serial_shift_clock = 1'h1;
			repeat (half) @(negedge i_ref_clk);
			o_serial_shift_clock = 1'h0;
			repeat (half) @(negedge i_ref_clk);
		end
		o_frame_sync_n = 1'h1;
		// Released data shows the inverse so no stale level can be mistaken for a bit.
		o_serial_data_in = ~o_serial_data_in;
		repeat (12) @(negedge i_ref_clk);
	endtask
endmodule

// ===== tb/sdri_bench.sv
// Self-checking bench for the serial DAC register interface.
`timescale 1ns/1ps
module sdri_bench;
	import sdri_pkg::*;
	logic i_ref_clk = 1'h0;
	logic i_srst = 1'h1;
	logic i_output_update_n = 1'h1;
	logic i_clear_n = 1'h1;
	logic frame_n;
	logic sclk;
	logic sdi;
	logic [79:0] main_code;
	logic [63:0] sub_code;
	logic [15:0] bias;
	logic [7:0] active;
	logic ref_on;
	logic coding;
	logic [9:0] min_code;
	logic [7:0] q_bias;
	logic [79:0] em;
	logic [63:0] es;
	int n_errors = 0;
	int samples_checked = 0;

	always #2 i_ref_clk = ~i_ref_clk;

	sdri_host_model host_u (.i_ref_clk(i_ref_clk), .o_frame_sync_n(frame_n),
		.o_serial_shift_clock(sclk), .o_serial_data_in(sdi));

	sdri_top #(.NUM_CH(8)) dut_u (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_frame_sync_n(frame_n),
		.i_serial_shift_clock(sclk), .i_serial_data_in(sdi), .i_output_update_n(i_output_update_n),
		.i_clear_n(i_clear_n), .o_main_code(main_code), .o_sub_code(sub_code), .o_bias_select(bias),
		.o_chan_active(active), .o_ref_on(ref_on), .o_coding_select(coding), .o_min_code(min_code));

	// The quad build shares the link and must fold the top address bit away.
	sdri_top #(.NUM_CH(4)) quad_u (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_frame_sync_n(frame_n),
		.i_serial_shift_clock(sclk), .i_serial_data_in(sdi), .i_output_update_n(i_output_update_n),
		.i_clear_n(i_clear_n), .o_main_code(), .o_sub_code(), .o_bias_select(q_bias),
		.o_chan_active(), .o_ref_on(), .o_coding_select(), .o_min_code());

	// ****
	// Helpers
	// ****
	task automatic check(input logic [143:0] seen, input logic [143:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] word);
		host_u.send(word, 16, 4);
	endtask

	task automatic pulse_update();
		@(negedge i_ref_clk);
		i_output_update_n = 1'h0;
		repeat (4) @(negedge i_ref_clk);
		i_output_update_n = 1'h1;
		repeat (6) @(negedge i_ref_clk);
	endtask

	task automatic print_verdict();
		$display("checked=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		check(ref_on, 1'h1);
		check(min_code, 10'h200);
		check(coding, 1'h0);
		check(active, 8'h00);
		check(bias, 16'h0000);
		check(main_code, 80'h0);
	endtask

	task automatic t_global();
		wr(16'h1c60);
		check(coding, 1'h1);
		check(min_code, 10'h000);
		check(active, 8'hff);
		wr(16'h0020);
		check(min_code, 10'h200);
		wr(16'h0000);
		check(ref_on, 1'h0);
		check(active, 8'h00);
		wr(16'h0030);
		check({ref_on, active}, 9'h100);
		wr(16'h0060);
		check(active, 8'hff);
	endtask

	task automatic t_chan_ctrl();
		for (int k = 0; k < 8; k++) begin
			wr({3'h2, k[2:0], k[2:1], 8'h10});
		end
		check(bias, 16'hfa50);
		check(q_bias, 8'hfa);
		wr({3'h2, 3'h5, 2'h2, 8'h00});
		check(active, 8'hdf);
		wr({3'h2, 3'h5, 2'h2, 8'h10});
		check(active, 8'hff);
	endtask

	task automatic t_data();
		wr({3'h3, 3'h2, 10'h2a5});
		wr({3'h5, 3'h2, 8'hc3, 2'h3});
		wr({3'h1, 3'h6, 10'h3ff});
		check(main_code, 80'h0);
		pulse_update();
		em = '0;
		em[20+:10] = 10'h2a5;
		em[60+:10] = 10'h3ff;
		es = 64'hc3 << 16;
		check(main_code, em);
		check(sub_code, es);
		wr({3'h2, 3'h2, 2'h1, 8'h18});
		check(main_code, em);
		pulse_update();
		check(main_code[20+:10], 10'h000);
		check(sub_code, es);
		wr({3'h2, 3'h2, 2'h1, 8'h10});
		pulse_update();
		check(main_code, em);
	endtask

	task automatic t_soft_clear();
		wr(16'h0068);
		check(main_code, 80'h0);
		check(sub_code, es);
		wr(16'h0060);
		pulse_update();
		check(main_code, 80'h0);
	endtask

	task automatic t_framing();
		host_u.send({3'h1, 3'h1, 10'h155}, 15, 4);
		host_u.send({3'h1, 3'h1, 10'h155}, 17, 4);
		pulse_update();
		check(main_code, 80'h0);
		wr({3'h1, 3'h1, 10'h155});
		pulse_update();
		check(main_code, 80'h155 << 10);
	endtask

	task automatic t_hw_clear();
		wr({3'h5, 3'h1, 8'h7e, 2'h0});
		pulse_update();
		check(sub_code, es | (64'h7e << 8));
		@(negedge i_ref_clk);
		i_clear_n = 1'h0;
		repeat (8) @(negedge i_ref_clk);
		check({main_code, sub_code}, 144'h0);
		i_clear_n = 1'h1;
		repeat (4) @(negedge i_ref_clk);
		pulse_update();
		check({main_code, sub_code}, 144'h0);
	endtask

	// A reset in mid-run must bring back the power-up defaults of every register.
	task automatic t_mid_reset();
		@(negedge i_ref_clk);
		i_srst = 1'h1;
		repeat (8) @(negedge i_ref_clk);
		i_srst = 1'h0;
		repeat (4) @(negedge i_ref_clk);
		t_reset();
		wr(16'h0020);
		check(active, 8'hff);
		wr({3'h1, 3'h0, 10'h1a5});
		pulse_update();
		check(main_code, 80'h0);
	endtask

	// ****
	// Main sequence and watchdog
	// ****
	initial begin
		repeat (8) @(negedge i_ref_clk);
		i_srst = 1'h0;
		repeat (4) @(negedge i_ref_clk);
		t_reset();
		t_global();
		t_chan_ctrl();
		t_data();
		t_soft_clear();
		t_framing();
		t_hw_clear();
		t_mid_reset();
		print_verdict();
	end

	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end
endmodule
